// >>> in_group_mux.sv
// Decoder for one remappable input group: select code to pad level
`timescale 1ns/100ps
module in_group_mux
	import pin_remap_pkg::*;
(
	input  wire logic [NUM_GRP_IN-1:0] grp_pins_i,
	input  wire logic [3:0]            rsv_mask_a_i,
	input  wire logic                  rsv_a_en_i,
	input  wire logic [3:0]            rsv_mask_b_i,
	input  wire logic                  rsv_b_en_i,
	input  wire logic [3:0]            sel_i,
	output logic                       level_o,
	output logic                       valid_o
);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	// Reserved codes connect nothing; input then reads low
	always_comb begin
		valid_o = !((rsv_a_en_i && sel_i == rsv_mask_a_i) ||
			(rsv_b_en_i && sel_i == rsv_mask_b_i));
		level_o = valid_o ? grp_pins_i[sel_i] : 1'b0;
	end

endmodule

// >>> pad_arbiter.sv
// Priority arbiter for one pad: analog, remapped output, fixed function, port
`timescale 1ns/100ps
module pad_arbiter
	import pin_remap_pkg::*;
(
	input  wire logic analog_en_i,
	input  wire logic remap_act_i,
	input  wire logic remap_dat_i,
	input  wire logic remap_oe_i,
	input  wire logic fixed_act_i,
	input  wire logic fixed_dat_i,
	input  wire logic fixed_oe_i,
	input  wire logic port_dat_i,
	input  wire logic port_oe_i,
	output logic      pad_dat_o,
	output logic      pad_oe_o
);

	// ----------------------------------------------------------------
	// Priority
	// ----------------------------------------------------------------
	always_comb begin
		if (analog_en_i) begin
			pad_dat_o = 1'b0;
			pad_oe_o  = 1'b0;
		end else if (remap_act_i) begin
			pad_dat_o = remap_dat_i;
			pad_oe_o  = remap_oe_i;
		end else if (fixed_act_i) begin
			pad_dat_o = fixed_dat_i;
			pad_oe_o  = fixed_oe_i;
		end else begin
			pad_dat_o = port_dat_i;
			pad_oe_o  = port_oe_i;
		end
	end

endmodule

// >>> peripheral_pin_remap.sv
// Peripheral pin remap: input select, output select, pad arbitration, lock
`timescale 1ns/100ps

module peripheral_pin_remap
	import pin_remap_pkg::*;
(
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire wb_req_t                wb_req_i,
	output wb_rsp_t                     wb_rsp_o,
	// Pads, synchronised inside
	input  wire logic [NUM_GRP_IN-1:0]  grp1_pad_i,
	input  wire logic [NUM_GRP_IN-1:0]  grp2_pad_i,
	input  wire logic [NUM_GRP_IN-1:0]  grp3_pad_i,
	output logic [NUM_INSEL-1:0]        periph_in_o,
	// Remappable peripheral outputs, indexed by output select code
	input  wire logic [15:0]            periph_out_dat_i,
	input  wire logic [15:0]            periph_out_oe_i,
	// Fixed-function and port drive per remappable pin
	input  wire logic [NUM_OUTPIN-1:0]  analog_en_i,
	input  wire logic [NUM_OUTPIN-1:0]  fixed_act_i,
	input  wire logic [NUM_OUTPIN-1:0]  fixed_dat_i,
	input  wire logic [NUM_OUTPIN-1:0]  fixed_oe_i,
	input  wire logic [NUM_OUTPIN-1:0]  port_dat_i,
	input  wire logic [NUM_OUTPIN-1:0]  port_oe_i,
	output logic [NUM_OUTPIN-1:0]       pad_dat_o,
	output logic [NUM_OUTPIN-1:0]       pad_oe_o,
	output logic                        locked_o
);

	// ----------------------------------------------------------------
	// Address decode helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] out_ofs(input int unsigned idx);
		logic [15:0] t;
		t = OFS_PIN_A14_OUT_SEL;
		case (idx)
			0:       t = OFS_PIN_A14_OUT_SEL;
			1:       t = OFS_PIN_A15_OUT_SEL;
			2:       t = OFS_PIN_B0_OUT_SEL;
			3:       t = OFS_PIN_B1_OUT_SEL;
			4:       t = OFS_PIN_B2_OUT_SEL;
			5:       t = OFS_PIN_B3_OUT_SEL;
			6:       t = OFS_PIN_B5_OUT_SEL;
			7:       t = OFS_PIN_B6_OUT_SEL;
			8:       t = OFS_PIN_B7_OUT_SEL;
			9:       t = OFS_PIN_B8_OUT_SEL;
			10:      t = OFS_PIN_B9_OUT_SEL;
			11:      t = OFS_PIN_B10_OUT_SEL;
			12:      t = OFS_PIN_B14_OUT_SEL;
			13:      t = OFS_PIN_B15_OUT_SEL;
			14:      t = OFS_PIN_C1_OUT_SEL;
			15:      t = OFS_PIN_C2_OUT_SEL;
			default: t = OFS_PIN_C3_OUT_SEL;
		endcase
		return t;
	endfunction

	function automatic logic [15:0] in_ofs(input int unsigned idx);
		return OFS_IN_SEL_BASE + 16'(idx * 4);
	endfunction

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [3:0]  out_sel_r [NUM_OUTPIN];
	logic [3:0]  in_sel_r  [NUM_INSEL];
	lock_state_t lock_st_r;
	logic        ack_r;
	logic [31:0] rdat_r;

	logic        bus_req;
	logic        bus_wr;
	logic        sel_wr_ok;
	logic        lo_lane;
	logic [31:0] rd_nxt;

	assign bus_req  = wb_req_i.cyc && wb_req_i.stb && !ack_r;
	assign bus_wr   = bus_req && wb_req_i.we;
	assign lo_lane  = wb_req_i.sel[0];
	// Select writes only land while open; stray stores cannot disturb a mapping
	assign sel_wr_ok = bus_wr && lo_lane && (lock_st_r == LK_OPEN);
	assign locked_o = (lock_st_r != LK_OPEN);

	// ----------------------------------------------------------------
	// Lock sequencer
	// ----------------------------------------------------------------
	// Two keys in order open it; a wrong second key re-locks, and key writes while open keep it open
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lock_st_r <= LK_LOCKED;
		end else if (bus_wr && wb_req_i.sel == 4'hf) begin
			if (wb_req_i.adr == OFS_UNLOCK_KEY) begin
				case (lock_st_r)
					LK_LOCKED: begin
						lock_st_r <= (wb_req_i.dat == UNLOCK_KEY_FIRST) ?
							LK_KEY1_SEEN : LK_LOCKED;
					end
					LK_KEY1_SEEN: begin
						lock_st_r <= (wb_req_i.dat == UNLOCK_KEY_SECOND) ?
							LK_OPEN : LK_LOCKED;
					end
					LK_OPEN: begin
						lock_st_r <= LK_OPEN;
					end
					default: begin
						lock_st_r <= LK_LOCKED;
					end
				endcase
			end else if (wb_req_i.adr == OFS_LOCK_CTRL && wb_req_i.dat[LOCK_BIT]) begin
				lock_st_r <= LK_LOCKED;
			end else if (lock_st_r == LK_KEY1_SEEN) begin
				lock_st_r <= LK_LOCKED;
			end
		end
	end

	// ----------------------------------------------------------------
	// Output select registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NUM_OUTPIN; i++) begin
				out_sel_r[i] <= SEL_RESET;
			end
		end else if (sel_wr_ok) begin
			for (int i = 0; i < NUM_OUTPIN; i++) begin
				if (wb_req_i.adr == out_ofs(i)) begin
					out_sel_r[i] <= wb_req_i.dat[SEL_LSB +: SEL_W];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Input select registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < NUM_INSEL; i++) begin
				in_sel_r[i] <= SEL_RESET;
			end
		end else if (sel_wr_ok) begin
			for (int i = 0; i < NUM_INSEL; i++) begin
				if (wb_req_i.adr == in_ofs(i)) begin
					in_sel_r[i] <= wb_req_i.dat[SEL_LSB +: SEL_W];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Bus read and ack
	// ----------------------------------------------------------------
	// Unmapped addresses still ack and read zero, so the master never hangs
	always_comb begin
		rd_nxt = 32'h0000_0000;
		for (int i = 0; i < NUM_OUTPIN; i++) begin
			if (wb_req_i.adr == out_ofs(i)) begin
				rd_nxt = {28'h0000000, out_sel_r[i]};
			end
		end
		for (int i = 0; i < NUM_INSEL; i++) begin
			if (wb_req_i.adr == in_ofs(i)) begin
				rd_nxt = {28'h0000000, in_sel_r[i]};
			end
		end
		if (wb_req_i.adr == OFS_LOCK_CTRL) begin
			rd_nxt = {31'h00000000, locked_o};
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= bus_req;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_r <= 32'h0000_0000;
		end else if (bus_req && !wb_req_i.we) begin
			rdat_r <= rd_nxt;
		end
	end

	assign wb_rsp_o.ack = ack_r;
	assign wb_rsp_o.dat = rdat_r;

	// ----------------------------------------------------------------
	// Pad input synchronisers
	// ----------------------------------------------------------------
	// Three stages; a change counts once stages two and three agree
	logic [3*NUM_GRP_IN-1:0] s1_r;
	logic [3*NUM_GRP_IN-1:0] s2_r;
	logic [3*NUM_GRP_IN-1:0] s3_r;
	logic [3*NUM_GRP_IN-1:0] filt_r;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_r   <= '0;
			s2_r   <= '0;
			s3_r   <= '0;
			filt_r <= '0;
		end else begin
			s1_r <= {grp3_pad_i, grp2_pad_i, grp1_pad_i};
			s2_r <= s1_r;
			s3_r <= s2_r;
			for (int b = 0; b < 3 * NUM_GRP_IN; b++) begin
				if (s2_r[b] == s3_r[b]) begin
					filt_r[b] <= s3_r[b];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Input routing
	// ----------------------------------------------------------------
	// Only plain digital inputs come through here; two-wire and analog stay fixed
	logic [NUM_INSEL-1:0] in_lvl;

	for (genvar g = 0; g < NUM_INSEL; g++) begin : g_in
		localparam int unsigned GRP = (g >= GRP3_FIRST) ? 2 : (g >= GRP2_FIRST) ? 1 : 0;
		logic [3:0] rsv_a;
		logic [3:0] rsv_b;
		logic       rsv_b_en;
		assign rsv_a    = (GRP == 0) ? GRP1_RSV_A : (GRP == 1) ? GRP2_RSV_A : GRP3_RSV_A;
		assign rsv_b    = (GRP == 2) ? GRP3_RSV_B : GRP1_RSV_B;
		assign rsv_b_en = (GRP != 1);
		in_group_mux u_mux (
			.grp_pins_i   (filt_r[GRP*NUM_GRP_IN +: NUM_GRP_IN]),
			.rsv_mask_a_i (rsv_a),
			.rsv_a_en_i   (1'b1),
			.rsv_mask_b_i (rsv_b),
			.rsv_b_en_i   (rsv_b_en),
			.sel_i        (in_sel_r[g]),
			.level_o      (in_lvl[g]),
			.valid_o      ()
		);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			periph_in_o <= '0;
		end else begin
			periph_in_o <= in_lvl;
		end
	end

	// ----------------------------------------------------------------
	// Output routing and pad arbitration
	// ----------------------------------------------------------------
	for (genvar p = 0; p < NUM_OUTPIN; p++) begin : g_out
		logic act;
		assign act = (out_sel_r[p] != SEL_RESET);
		pad_arbiter u_arb (
			.analog_en_i (analog_en_i[p]),
			.remap_act_i (act),
			.remap_dat_i (periph_out_dat_i[out_sel_r[p]]),
			.remap_oe_i  (periph_out_oe_i[out_sel_r[p]]),
			.fixed_act_i (fixed_act_i[p]),
			.fixed_dat_i (fixed_dat_i[p]),
			.fixed_oe_i  (fixed_oe_i[p]),
			.port_dat_i  (port_dat_i[p]),
			.port_oe_i   (port_oe_i[p]),
			.pad_dat_o   (pad_dat_o[p]),
			.pad_oe_o    (pad_oe_o[p])
		);
	end

endmodule

// >>> peripheral_pin_remap_properties.sv
// Concurrent checker for the peripheral pin remap block
`timescale 1ns/100ps
module peripheral_pin_remap_properties
	import pin_remap_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire wb_req_t               wb_req_i,
	input  wire wb_rsp_t               wb_rsp_o,
	input  wire logic [NUM_INSEL-1:0]  periph_in_o,
	input  wire logic [NUM_OUTPIN-1:0] analog_en_i,
	input  wire logic [NUM_OUTPIN-1:0] fixed_act_i,
	input  wire logic [NUM_OUTPIN-1:0] fixed_oe_i,
	input  wire logic [NUM_OUTPIN-1:0] port_oe_i,
	input  wire logic [NUM_OUTPIN-1:0] pad_dat_o,
	input  wire logic [NUM_OUTPIN-1:0] pad_oe_o,
	input  wire logic                  locked_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	AST_ACK_TAKEN:
	assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack |=> wb_rsp_o.ack)
		else $error("ack missing one cycle after a request");
	AST_ANALOG_WINS:
	assert property ((analog_en_i & (pad_oe_o | pad_dat_o)) == '0)
		else $error("pad driven while analog function enabled");
	AST_RESET_LOCKED:
	assert property ($fell(rst_i) |-> locked_o)
		else $error("map not locked after reset");
	AST_RESET_INPUTS:
	assert property ($fell(rst_i) |-> periph_in_o == '0)
		else $error("peripheral input connected after reset");
	AST_RESET_PADS:
	assert property ($fell(rst_i) |-> pad_oe_o ==
		(((fixed_act_i & fixed_oe_i) | (~fixed_act_i & port_oe_i)) & ~analog_en_i))
		else $error("pad not left to fixed or port after reset");
	// Only a key write may open the lock
	AST_LOCK_HOLDS:
	assert property (locked_o && !(wb_req_i.cyc && wb_req_i.stb && wb_req_i.we
		&& wb_req_i.adr == OFS_UNLOCK_KEY) |=> locked_o)
		else $error("lock opened without key write");
	AST_UNLOCK_CAUSE:
	assert property ($fell(locked_o) |-> $past(wb_req_i.adr) == OFS_UNLOCK_KEY)
		else $error("unlock not caused by key register");
	AST_RELOCK_CAUSE:
	assert property ($rose(locked_o) |-> $past(wb_req_i.adr) == OFS_LOCK_CTRL)
		else $error("relock not caused by lock control write");

	COV_UNLOCK: cover property ($fell(locked_o));
	COV_RELOCK: cover property ($rose(locked_o));
	COV_ANALOG: cover property (|(analog_en_i & port_oe_i));
endmodule

bind peripheral_pin_remap peripheral_pin_remap_properties u_props (
	.clk_i       (clk_i),
	.rst_i       (rst_i),
	.wb_req_i    (wb_req_i),
	.wb_rsp_o    (wb_rsp_o),
	.periph_in_o (periph_in_o),
	.analog_en_i (analog_en_i),
	.fixed_act_i (fixed_act_i),
	.fixed_oe_i  (fixed_oe_i),
	.port_oe_i   (port_oe_i),
	.pad_dat_o   (pad_dat_o),
	.pad_oe_o    (pad_oe_o),
	.locked_o    (locked_o)
);

// >>> peripheral_pin_remap_tb.sv
// Self-checking testbench for the peripheral pin remap block
`timescale 1ns/100ps
module peripheral_pin_remap_tb
	import pin_remap_pkg::*;
;
	logic                  clk_i;
	logic                  rst_i;
	wb_req_t               req;
	wb_rsp_t               rsp;
	logic [NUM_GRP_IN-1:0] gp [3];
	logic [NUM_INSEL-1:0]  pin_o;
	logic [15:0]           po_dat, po_oe;
	logic [NUM_OUTPIN-1:0] an, fa, fd, fo, pd, po, pad_d, pad_oe;
	logic                  locked;
	logic [31:0]           q;
	int                    err_count;
	int                    total_checks;

	peripheral_pin_remap u_dut (
		.clk_i           (clk_i),
		.rst_i           (rst_i),
		.wb_req_i        (req),
		.wb_rsp_o        (rsp),
		.grp1_pad_i      (gp[0]),
		.grp2_pad_i      (gp[1]),
		.grp3_pad_i      (gp[2]),
		.periph_in_o     (pin_o),
		.periph_out_dat_i(po_dat),
		.periph_out_oe_i (po_oe),
		.analog_en_i     (an),
		.fixed_act_i     (fa),
		.fixed_dat_i     (fd),
		.fixed_oe_i      (fo),
		.port_dat_i      (pd),
		.port_oe_i       (po),
		.pad_dat_o       (pad_d),
		.pad_oe_o        (pad_oe),
		.locked_o        (locked)
	);

	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// Ack and read data are taken at the rising edge that samples ack high
	task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d);
		req <= '{dat: d, adr: a, sel: 4'hf, we: w, cyc: 1'b1, stb: 1'b1};
		do begin
			@(posedge clk_i);
		end while (rsp.ack !== 1'b1);
		q = rsp.dat;
		req.cyc <= 1'b0;
		req.stb <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic conclude();
		if (err_count == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic lock_test();
		wb(1'b0, OFS_LOCK_CTRL, '0);
		chk(32'(q[LOCK_BIT]), 32'h1);
		wb(1'b1, OFS_PIN_A14_OUT_SEL, 32'h5);
		wb(1'b0, OFS_PIN_A14_OUT_SEL, '0);
		chk(q, 32'h0);
		wb(1'b0, OFS_PIN_C3_OUT_SEL, '0);
		chk(q, 32'h0);
		wb(1'b0, 16'hfb50, '0);
		chk(q, 32'h0);
		// Broken key sequence must leave the map locked
		wb(1'b1, OFS_UNLOCK_KEY, UNLOCK_KEY_FIRST);
		wb(1'b1, OFS_UNLOCK_KEY, 32'h0);
		wb(1'b1, OFS_UNLOCK_KEY, UNLOCK_KEY_SECOND);
		chk(32'(locked), 32'h1);
		wb(1'b1, OFS_UNLOCK_KEY, UNLOCK_KEY_FIRST);
		wb(1'b1, OFS_UNLOCK_KEY, UNLOCK_KEY_SECOND);
		chk(32'(locked), 32'h0);
	endtask

	task automatic out_test();
		wb(1'b1, OFS_PIN_B0_OUT_SEL, 32'hffff_fff5);
		wb(1'b0, OFS_PIN_B0_OUT_SEL, '0);
		chk(q, 32'h5);
		// Code 0 source driven high too, so a stray code 0 drive shows
		po_dat <= '1;
		po_oe <= '1;
		fa <= '1;
		fo <= '1;
		pd <= '1;
		po <= '1;
		@(negedge clk_i);
		chk(32'({pad_oe[2], pad_d[2], pad_oe[0], pad_d[0]}), 32'he);
		@(posedge clk_i);
		fa <= '0;
		an <= 17'h00004;
		@(negedge clk_i);
		chk(32'({pad_oe[2], pad_d[2], pad_oe[0], pad_d[0]}), 32'h3);
		@(posedge clk_i);
		an <= '0;
	endtask

	task automatic in_test();
		logic rsv;
		for (int g = 0; g < 3; g++) begin
			for (int c = 0; c < 16; c++) begin
				wb(1'b1, OFS_IN_SEL_BASE + 16'(28 * g), 32'(c));
				gp[g] <= 16'h1 << c;
				repeat (8) @(posedge clk_i);
				rsv = (c == 14 && g != 1) || (c == 9 && g != 2) || (c == 8 && g == 2);
				chk(32'(pin_o[7 * g]), 32'(!rsv));
				gp[g] <= '0;
			end
		end
	endtask

	task automatic relock_test();
		wb(1'b0, OFS_IN_SEL_BASE + 16'h0038, '0);
		chk(q, 32'hf);
		wb(1'b1, OFS_LOCK_CTRL, 32'h1);
		chk(32'(locked), 32'h1);
		wb(1'b1, OFS_PIN_B0_OUT_SEL, 32'h0);
		wb(1'b0, OFS_PIN_B0_OUT_SEL, '0);
		chk(q, 32'h5);
	endtask

	// Mid-run reset after a mapping was set up: everything back to idle
	task automatic reset_test();
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		chk(32'(locked), 32'h1);
		wb(1'b0, OFS_PIN_B0_OUT_SEL, '0);
		chk(q, 32'h0);
		wb(1'b0, OFS_IN_SEL_BASE + 16'h0038, '0);
		chk(q, 32'h0);
		wb(1'b1, OFS_IN_SEL_BASE, 32'h3);
		wb(1'b0, OFS_IN_SEL_BASE, '0);
		chk(q, 32'h0);
		chk(32'(pin_o), 32'h0);
	endtask

	initial begin
		err_count = 0;
		total_checks = 0;
		rst_i = 1'b1;
		req = '0;
		gp[0] = '0;
		gp[1] = '0;
		gp[2] = '0;
		po_dat = '0;
		po_oe = '0;
		an = '0;
		fa = '0;
		fd = '0;
		fo = '0;
		pd = '0;
		po = '0;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		lock_test();
		out_test();
		in_test();
		relock_test();
		reset_test();
		conclude();
	end

	// Whole run needs about 12 us
	initial begin
		#200000;
		err_count++;
		conclude();
	end
endmodule

// >>> pin_remap_pkg.sv
// Package with register map, field layouts and pin indices for the pin remap block
package pin_remap_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int unsigned SEL_W      = 4;
	localparam int unsigned NUM_OUTPIN = 17;
	localparam int unsigned NUM_INSEL  = 21;
	localparam int unsigned NUM_GRP_IN = 16;
	localparam int unsigned ADDR_W     = 16;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [15:0] OFS_PIN_A14_OUT_SEL = 16'hfb38;
	localparam logic [15:0] OFS_PIN_A15_OUT_SEL = 16'hfb3c;
	localparam logic [15:0] OFS_PIN_B0_OUT_SEL  = 16'hfb40;
	localparam logic [15:0] OFS_PIN_B1_OUT_SEL  = 16'hfb44;
	localparam logic [15:0] OFS_PIN_B2_OUT_SEL  = 16'hfb48;
	localparam logic [15:0] OFS_PIN_B3_OUT_SEL  = 16'hfb4c;
	localparam logic [15:0] OFS_PIN_B5_OUT_SEL  = 16'hfb54;
	localparam logic [15:0] OFS_PIN_B6_OUT_SEL  = 16'hfb58;
	localparam logic [15:0] OFS_PIN_B7_OUT_SEL  = 16'hfb5c;
	localparam logic [15:0] OFS_PIN_B8_OUT_SEL  = 16'hfb60;
	localparam logic [15:0] OFS_PIN_B9_OUT_SEL  = 16'hfb64;
	localparam logic [15:0] OFS_PIN_B10_OUT_SEL = 16'hfb68;
	localparam logic [15:0] OFS_PIN_B14_OUT_SEL = 16'hfb78;
	localparam logic [15:0] OFS_PIN_B15_OUT_SEL = 16'hfb7c;
	localparam logic [15:0] OFS_PIN_C1_OUT_SEL  = 16'hfb84;
	localparam logic [15:0] OFS_PIN_C2_OUT_SEL  = 16'hfb88;
	localparam logic [15:0] OFS_PIN_C3_OUT_SEL  = 16'hfb8c;
	// Input select registers: base plus four times the input index
	localparam logic [15:0] OFS_IN_SEL_BASE     = 16'hfa00;
	localparam logic [15:0] OFS_LOCK_CTRL       = 16'hf9f0;
	localparam logic [15:0] OFS_UNLOCK_KEY      = 16'hf9f4;

	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam int unsigned SEL_LSB          = 0;
	localparam int unsigned LOCK_BIT         = 0;
	localparam logic [3:0]  SEL_RESET        = 4'h0;
	localparam logic        LOCK_RESET       = 1'b0;
	localparam logic [31:0] UNLOCK_KEY_FIRST  = 32'haa99_6655;
	localparam logic [31:0] UNLOCK_KEY_SECOND = 32'h5566_99aa;

	// Reserved codes per input group
	localparam logic [3:0] GRP1_RSV_A = 4'h9;
	localparam logic [3:0] GRP1_RSV_B = 4'he;
	localparam logic [3:0] GRP2_RSV_A = 4'h9;
	localparam logic [3:0] GRP3_RSV_A = 4'h8;
	localparam logic [3:0] GRP3_RSV_B = 4'he;

	// ----------------------------------------------------------------
	// Input index assignment (group 1: 0..6, group 2: 7..13, group 3: 14..20)
	// ----------------------------------------------------------------
	localparam int unsigned GRP2_FIRST = 7;
	localparam int unsigned GRP3_FIRST = 14;

	typedef struct packed {
		logic [31:0] dat;
		logic [15:0] adr;
		logic [3:0]  sel;
		logic        we;
		logic        cyc;
		logic        stb;
	} wb_req_t;

	typedef struct packed {
		logic [31:0] dat;
		logic        ack;
	} wb_rsp_t;

	typedef enum logic [1:0] {
		LK_LOCKED,
		LK_KEY1_SEEN,
		LK_OPEN
	} lock_state_t;

endpackage
